// ---- hdl/flic_ctrl.sv ----
// Purpose: four-level nested interrupt controller for fifteen sources
// Assumes: core acks a taken request with a one-cycle pulse, and returns with one pulse
// Notes:   pin inputs pass a two-stage synchroniser before edge detection
`timescale 1ns/1ps
`include "flic_map.svh"

module flic_ctrl
   import flic_pkg::*;
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          reset_n,
   // register port
   input  wire logic [7:0]    sfr_addr,
   input  wire logic          sfr_wr,
   input  wire logic          sfr_rd,
   input  wire logic [7:0]    sfr_wdata,
   output logic      [7:0]    sfr_rdata_ff,
   // pins
   input  wire logic          external_request_zero,
   input  wire logic          external_request_one,
   input  wire logic [3:0]    capture_input,
   // peripherals
   input  flic_per_ev_s       per_ev,
   input  flic_timer_s        timer,
   // processor core
   input  wire logic          cpu_ack,
   input  wire logic          cpu_return,
   output flic_cpu_req_s      cpu_req_ff,
   output logic      [3:0]    in_service_ff
);

   localparam int NSRC = 15;

   // fixed order within a level, highest first, as source ids
   localparam flic_src_t ORDER [NSRC] = '{
      4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
      4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he
   };

   // spread two byte registers onto the fifteen source ids
   function automatic logic [NSRC-1:0] spread(input logic [7:0] first,
                                              input logic [7:0] second);
      logic [NSRC-1:0] v;
      v        = '0;
      v[5:0]   = first[5:0];
      v[10]    = first[`FLIC_BIT_ADC_FIRST];
      v[9:6]   = second[3:0];
      v[13:11] = second[6:4];
      v[14]    = second[7];
      return v;
   endfunction : spread

   logic [7:0]       enable_reg_first_ff;
   logic [7:0]       enable_reg_second_ff;
   logic [7:0]       priority_low_bits_first_ff;
   logic [7:0]       priority_high_bits_first_ff;
   logic [7:0]       priority_low_bits_second_ff;
   logic [7:0]       priority_high_bits_second_ff;
   logic [15:0]      flags_ff;
   logic [5:0]       pin_meta_ff;
   logic [5:0]       pin_sync_ff;
   logic [5:0]       pin_prev_ff;
   logic [15:0]      hw_set;
   logic [5:0]       pin_rise;
   logic             wr_flags_lo;
   logic             wr_flags_hi;
   logic [15:0]      wr_mask;
   logic [15:0]      wr_dup;
   logic [NSRC-1:0]  pend;
   logic [NSRC-1:0]  en_vec;
   logic [NSRC-1:0]  plo_vec;
   logic [NSRC-1:0]  phi_vec;
   logic [NSRC-1:0]  req_on;
   flic_level_t      src_lvl [NSRC];
   logic             found;
   flic_src_t        best_src;
   flic_level_t      best_lvl;
   logic             srv_any;
   flic_level_t      srv_top;
   logic             may_take;
   logic [3:0]       nxt_in_service;
   logic [7:0]       nxt_rdata;

   // pins: two flops before anything looks at them
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pin_meta_ff <= `FLIC_RST_PINS;
         pin_sync_ff <= `FLIC_RST_PINS;
         pin_prev_ff <= `FLIC_RST_PINS;
      end else begin
         pin_meta_ff <= {capture_input, external_request_one, external_request_zero};
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   assign pin_rise = pin_sync_ff & ~pin_prev_ff;

   // hardware set terms, one per flag bit
   always_comb begin
      hw_set     = `FLIC_RST_FLAGS;
      hw_set[0]  = pin_rise[0];
      hw_set[1]  = per_ev.timer0_ovf;
      hw_set[2]  = pin_rise[1];
      hw_set[3]  = per_ev.timer1_ovf;
      hw_set[4]  = per_ev.uart_event;
      hw_set[5]  = per_ev.twowire_status_load;
      hw_set[9:6] = pin_rise[5:2];
      hw_set[`FLIC_FLAG_ADC] = per_ev.conv_done;
      hw_set[11] = timer.tick && (timer.count == timer.compare_reg_zero);
      hw_set[12] = timer.tick && (timer.count == timer.compare_reg_one);
      hw_set[13] = timer.tick && (timer.count == timer.compare_reg_two);
      hw_set[`FLIC_FLAG_BYTE_OVF] = timer.tick && (timer.count[7:0] == `FLIC_BYTE_MAX);
      hw_set[`FLIC_FLAG_FULL_OVF] = timer.tick && (timer.count == `FLIC_FULL_MAX);
   end

   assign wr_flags_lo = sfr_wr && (sfr_addr == `FLIC_ADDR_FLAGS_LOW);
   assign wr_flags_hi = sfr_wr && (sfr_addr == `FLIC_ADDR_FLAGS_HIGH);
   // both bytes see the same data so no bit index ever runs below zero
   assign wr_mask     = {{8{wr_flags_hi}}, {8{wr_flags_lo}}};
   assign wr_dup      = {sfr_wdata, sfr_wdata};

   // request flags: a hardware set always wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         flags_ff <= `FLIC_RST_FLAGS;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (wr_mask[i] && i == `FLIC_FLAG_ADC) begin
               // a written one cannot fake a finished conversion
               flags_ff[i] <= (flags_ff[i] & wr_dup[i]) | hw_set[i];
            end else if (wr_mask[i]) begin
               flags_ff[i] <= wr_dup[i] | hw_set[i];
            end else begin
               flags_ff[i] <= flags_ff[i] | hw_set[i];
            end
         end
      end
   end

   // enable and priority registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         enable_reg_first_ff          <= `FLIC_RST_BYTE;
         enable_reg_second_ff         <= `FLIC_RST_BYTE;
         priority_low_bits_first_ff   <= `FLIC_RST_BYTE;
         priority_high_bits_first_ff  <= `FLIC_RST_BYTE;
         priority_low_bits_second_ff  <= `FLIC_RST_BYTE;
         priority_high_bits_second_ff <= `FLIC_RST_BYTE;
      end else if (sfr_wr) begin
         case (sfr_addr)
            `FLIC_ADDR_ENABLE_FIRST:     enable_reg_first_ff  <= sfr_wdata;
            `FLIC_ADDR_ENABLE_SECOND:    enable_reg_second_ff <= sfr_wdata;
            `FLIC_ADDR_PRIO_LOW_FIRST: begin
               priority_low_bits_first_ff <= sfr_wdata;
               priority_low_bits_first_ff[`FLIC_BIT_UNUSED_FIRST] <= 1'b0;
            end
            `FLIC_ADDR_PRIO_HIGH_FIRST: begin
               priority_high_bits_first_ff <= sfr_wdata;
               priority_high_bits_first_ff[`FLIC_BIT_UNUSED_FIRST] <= 1'b0;
            end
            `FLIC_ADDR_PRIO_LOW_SECOND:  priority_low_bits_second_ff  <= sfr_wdata;
            `FLIC_ADDR_PRIO_HIGH_SECOND: priority_high_bits_second_ff <= sfr_wdata;
            default: ;
         endcase
      end
   end

   // per-source views
   always_comb begin
      pend     = flags_ff[NSRC-1:0];
      pend[14] = flags_ff[`FLIC_FLAG_BYTE_OVF] | flags_ff[`FLIC_FLAG_FULL_OVF];
      en_vec   = spread(enable_reg_first_ff, enable_reg_second_ff);
      plo_vec  = spread(priority_low_bits_first_ff, priority_low_bits_second_ff);
      phi_vec  = spread(priority_high_bits_first_ff, priority_high_bits_second_ff);
      req_on   = pend & en_vec
               & {NSRC{enable_reg_first_ff[`FLIC_BIT_GLOBAL_GATE]}};
   end

   // per-source level, high priority bit above the low one
   for (genvar s = 0; s < NSRC; s++) begin : g_lvl
      assign src_lvl[s] = {phi_vec[s], plo_vec[s]};
   end

   // winner: highest level first, then fixed order; scanning highest order first
   // and taking only a strictly higher level keeps the earlier source on a tie
   always_comb begin
      found    = 1'b0;
      best_src = 4'h0;
      best_lvl = 2'h0;
      for (int k = 0; k < NSRC; k++) begin
         if (req_on[ORDER[k]] && (!found || src_lvl[ORDER[k]] > best_lvl)) begin
            found    = 1'b1;
            best_src = ORDER[k];
            best_lvl = src_lvl[ORDER[k]];
         end
      end
   end

   // highest level now in service
   always_comb begin
      srv_any = |in_service_ff;
      srv_top = 2'h0;
      for (int l = 0; l < 4; l++) begin
         if (in_service_ff[l]) begin
            srv_top = 2'(l);
         end
      end
      may_take = found && (!srv_any || best_lvl > srv_top);
   end

   // request offered to the core, refreshed every cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cpu_req_ff <= '0;
      end else begin
         cpu_req_ff.valid <= may_take && !cpu_ack;
         cpu_req_ff.src   <= best_src;
         cpu_req_ff.level <= best_lvl;
      end
   end

   // in-service levels: return drops the top one, ack adds the taken one
   always_comb begin
      nxt_in_service = in_service_ff;
      if (cpu_return) begin
         for (int l = 0; l < 4; l++) begin
            if (l == int'(srv_top)) begin
               nxt_in_service[l] = 1'b0;
            end
         end
      end
      if (cpu_ack && cpu_req_ff.valid) begin
         nxt_in_service[cpu_req_ff.level] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         in_service_ff <= `FLIC_RST_LEVELS;
      end else begin
         in_service_ff <= nxt_in_service;
      end
   end

   // register reads; unmapped offsets read zero
   always_comb begin
      case (sfr_addr)
         `FLIC_ADDR_ENABLE_FIRST:     nxt_rdata = enable_reg_first_ff;
         `FLIC_ADDR_ENABLE_SECOND:    nxt_rdata = enable_reg_second_ff;
         `FLIC_ADDR_PRIO_LOW_FIRST:   nxt_rdata = priority_low_bits_first_ff;
         `FLIC_ADDR_PRIO_HIGH_FIRST:  nxt_rdata = priority_high_bits_first_ff;
         `FLIC_ADDR_PRIO_LOW_SECOND:  nxt_rdata = priority_low_bits_second_ff;
         `FLIC_ADDR_PRIO_HIGH_SECOND: nxt_rdata = priority_high_bits_second_ff;
         `FLIC_ADDR_FLAGS_LOW:        nxt_rdata = flags_ff[7:0];
         `FLIC_ADDR_FLAGS_HIGH:       nxt_rdata = flags_ff[15:8];
         `FLIC_ADDR_IN_SERVICE:       nxt_rdata = {4'h0, in_service_ff};
         default:                     nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sfr_rdata_ff <= `FLIC_RST_BYTE;
      end else if (sfr_rd) begin
         sfr_rdata_ff <= nxt_rdata;
      end
   end

endmodule : flic_ctrl

// ---- hdl/flic_map.svh ----
// Purpose: offsets, field positions and reset values of the interrupt controller
// Assumes: 8-bit special function register space, byte-wide registers
// Notes:   included by the controller only
`ifndef FLIC_MAP_SVH
`define FLIC_MAP_SVH

// register offsets
`define FLIC_ADDR_ENABLE_FIRST        8'ha8
`define FLIC_ADDR_ENABLE_SECOND       8'he8
`define FLIC_ADDR_PRIO_LOW_FIRST      8'hb8
`define FLIC_ADDR_PRIO_HIGH_FIRST     8'hb7
`define FLIC_ADDR_PRIO_LOW_SECOND     8'hf8
`define FLIC_ADDR_PRIO_HIGH_SECOND    8'hf7
`define FLIC_ADDR_FLAGS_LOW           8'hc8
`define FLIC_ADDR_FLAGS_HIGH          8'hc9
`define FLIC_ADDR_IN_SERVICE          8'hca

// reset values
`define FLIC_RST_BYTE                 8'h00
`define FLIC_RST_FLAGS                16'h0000
`define FLIC_RST_LEVELS               4'h0
`define FLIC_RST_PINS                 6'h00

// field positions
`define FLIC_BIT_GLOBAL_GATE          7
`define FLIC_BIT_UNUSED_FIRST         7
`define FLIC_BIT_ADC_FIRST            6
`define FLIC_FLAG_ADC                 10
`define FLIC_FLAG_BYTE_OVF            14
`define FLIC_FLAG_FULL_OVF            15

// timer limits
`define FLIC_BYTE_MAX                 8'hff
`define FLIC_FULL_MAX                 16'hffff

`endif

// ---- hdl/flic_pkg.sv ----
// Purpose: types shared by the interrupt controller and its users
// Assumes: fifteen sources, four levels
// Notes:   source ids follow the vector table order
package flic_pkg;

   typedef logic [3:0] flic_src_t;
   typedef logic [1:0] flic_level_t;

   // events from peripherals on the same clock, one-cycle pulses
   typedef struct packed {
      logic timer0_ovf;
      logic timer1_ovf;
      logic uart_event;
      logic twowire_status_load;
      logic conv_done;
   } flic_per_ev_s;

   // capture/compare timer view
   typedef struct packed {
      logic        tick;
      logic [15:0] count;
      logic [15:0] compare_reg_two;
      logic [15:0] compare_reg_one;
      logic [15:0] compare_reg_zero;
   } flic_timer_s;

   // request to the processor core
   typedef struct packed {
      logic        valid;
      flic_level_t level;
      flic_src_t   src;
   } flic_cpu_req_s;

endpackage : flic_pkg

// ---- sim/flic_checker.sv ----
// Purpose: port checks of the interrupt controller
// Assumes: one clock, synchronous active-low reset
// Notes:   gate bit shadowed from register writes
`timescale 1ns/1ps
module flic_checker
   import flic_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata_ff,
   input wire logic       cpu_ack,
   input wire logic       cpu_return,
   input flic_cpu_req_s   cpu_req_ff,
   input wire logic [3:0] in_service_ff
);
   logic       gate_ff;
   logic [3:0] top;
   always_comb top = in_service_ff[3] ? 4'h8 : in_service_ff[2] ? 4'h4 :
                     in_service_ff[1] ? 4'h2 : {3'h0, in_service_ff[0]};
   always_ff @(posedge ref_clk) begin
      if (!reset_n) gate_ff <= 1'b0;
      else if (sfr_wr && sfr_addr == 8'ha8) gate_ff <= sfr_wdata[7];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence take_s; cpu_ack && cpu_req_ff.valid; endsequence
   sequence pop_s; cpu_return && !cpu_ack; endsequence
   gate_blocks_a: assert property (!gate_ff |=> !cpu_req_ff.valid)
      else $error("request offered with gate clear");
   ack_drop_a: assert property (take_s |=> !cpu_req_ff.valid)
      else $error("offer kept after ack");
   ack_level_a: assert property (take_s |=> in_service_ff[$past(cpu_req_ff.level)])
      else $error("taken level not in service");
   offer_above_a: assert property (
      cpu_req_ff.valid |-> (in_service_ff >> cpu_req_ff.level) == 4'h0)
      else $error("offer not above service level");
   pop_top_a: assert property (
      pop_s |=> in_service_ff == ($past(in_service_ff) & ~$past(top)))
      else $error("return did not pop top level");
   keep_service_a: assert property (
      !cpu_return |=> (in_service_ff & $past(in_service_ff)) == $past(in_service_ff))
      else $error("service level lost without return");
   idle_stable_a: assert property (
      !(cpu_ack && cpu_req_ff.valid) && !cpu_return |=> $stable(in_service_ff))
      else $error("service changed without ack or return");
   prio_bit7_a: assert property (sfr_rd && sfr_addr == 8'hb8 |=> !sfr_rdata_ff[7])
      else $error("unused priority bit read high");
   rd_unmapped_a: assert property (
      sfr_rd && !(sfr_addr inside {8'ha8, 8'he8, 8'hb8, 8'hb7, 8'hf8, 8'hf7,
      8'hc8, 8'hc9, 8'hca}) |=> sfr_rdata_ff == 8'h00)
      else $error("unmapped read not zero");
endmodule : flic_checker

bind flic_ctrl flic_checker chk (.ref_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata_ff, .cpu_ack, .cpu_return, .cpu_req_ff, .in_service_ff);

// ---- sim/flic_core_model.sv ----
// Purpose: behavioural processor core taking offered requests
// Assumes: bench enables acks and orders returns
// Notes:   an offer stands lag plus one cycles before ack
`timescale 1ns/1ps
module flic_core_model
   import flic_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // bench controls
   input  wire logic       ack_en,
   input  wire logic [1:0] lag,
   input  wire logic       ret_go,
   // controller side
   input  flic_cpu_req_s   cpu_req_ff,
   output logic            ack_ff,
   output logic            ret_ff
);
   logic [1:0] wait_ff;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wait_ff <= 2'h0;
         ack_ff  <= 1'b0;
         ret_ff  <= 1'b0;
      end else begin
         ret_ff  <= ret_go;
         ack_ff  <= 1'b0;
         wait_ff <= 2'h0;
         // no ack while the last one is still on the wire
         if (ack_en && cpu_req_ff.valid && !ack_ff) begin
            if (wait_ff == lag) ack_ff <= 1'b1;
            else wait_ff <= wait_ff + 2'h1;
         end
      end
   end
endmodule : flic_core_model

// ---- sim/four_level_interrupt_controller_test.sv ----
// Purpose: self-checking bench of the interrupt controller
// Assumes: flag bit n of the flag word belongs to source id n
// Notes:   full overflow sits at bit 15 and shares source 14
`timescale 1ns/1ps
module four_level_interrupt_controller_test
   import flic_pkg::*;
;
   logic          ref_clk, reset_n, sfr_wr, sfr_rd, cpu_ack, cpu_return;
   logic [7:0]    sfr_addr, sfr_wdata, sfr_rdata_ff;
   logic          external_request_zero, external_request_one, ack_en, ret_go;
   logic [3:0]    capture_input, in_service_ff;
   logic [1:0]    lag;
   logic [15:0]   fl;
   flic_per_ev_s  per_ev;
   flic_timer_s   timer;
   flic_cpu_req_s cpu_req_ff;
   int            miscompares, check_count, cycles;
   // event bits, flag word, expected source
   logic [24:0] rows [20] = '{25'h0000010, 25'h0000021, 25'h0000042, 25'h0000083,
      25'h0000104, 25'h0000205, 25'h0000406, 25'h0000807, 25'h0001008, 25'h0002009,
      25'h000800b, 25'h001000c, 25'h002000d, 25'h004000e, 25'h008000e, 25'h010400a,
      25'h0200205, 25'h0400104, 25'h0800083, 25'h1000021};
   logic [3:0] order [15] = '{4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
      4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};
   logic [7:0] rmap [10] = '{8'ha8, 8'he8, 8'hb8, 8'hb7, 8'hf8, 8'hf7, 8'hc8, 8'hc9,
      8'hca, 8'h01};

   flic_ctrl uut (.ref_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata_ff, .external_request_zero, .external_request_one, .capture_input,
      .per_ev, .timer, .cpu_ack, .cpu_return, .cpu_req_ff, .in_service_ff);
   flic_core_model core (.ref_clk, .reset_n, .ack_en, .lag, .ret_go, .cpu_req_ff,
      .ack_ff(cpu_ack), .ret_ff(cpu_return));

   task automatic test_done();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp_req(input flic_cpu_req_s got, input logic [6:0] exp);
      cmp8({1'b0, got}, {1'b0, exp});
   endtask : cmp_req
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      tick(1);
      sfr_addr = a; sfr_rd = 1'b1;
      tick(1);
      sfr_rd = 1'b0;
      cmp8(sfr_rdata_ff, exp);
   endtask : rd
   task automatic flags(input logic [15:0] v);
      wr(8'hc8, v[7:0]);
      wr(8'hc9, v[15:8]);
   endtask : flags
   task automatic ev(input logic [4:0] v);
      tick(1);
      per_ev = v;
      tick(1);
      per_ev = '0;
   endtask : ev
   task automatic hw(input logic [15:0] exp);
      tick(5);
      external_request_zero = 1'b0; capture_input = 4'h0; timer.tick = 1'b0;
      rd(8'hc8, exp[7:0]);
      rd(8'hc9, exp[15:8]);
      flags(16'h0000);
   endtask : hw
   task automatic wis(input logic [3:0] exp);
      int i;
      for (i = 0; i < 12 && in_service_ff !== exp; i++) tick(1);
      cmp8({4'h0, in_service_ff}, {4'h0, exp});
   endtask : wis
   task automatic ret();
      tick(1);
      ret_go = 1'b1;
      tick(1);
      ret_go = 1'b0;
   endtask : ret

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // hang guard, the whole run needs well under 2000 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         test_done();
      end
   end

   initial begin
      {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, capture_input, per_ev, timer} = '0;
      {external_request_zero, external_request_one, ack_en, lag, ret_go} = '0;
      reset_n = 1'b0;
      tick(2);
      reset_n = 1'b1;
      cmp_req(cpu_req_ff, 7'h00);
      cmp8({4'h0, in_service_ff}, 8'h00);
      wr(8'h01, 8'hff);
      foreach (rmap[k]) rd(rmap[k], 8'h00);
      wr(8'ha8, 8'hff);
      wr(8'he8, 8'hff);
      foreach (rows[k]) begin
         if (rows[k][24:20] != 5'h00) ev(rows[k][24:20]);
         else flags(rows[k][19:4]);
         tick(1);
         cmp_req(cpu_req_ff, {3'h4, rows[k][3:0]});
         rd(8'hc8, rows[k][11:4]);
         rd(8'hc9, rows[k][19:12]);
         flags(16'h0000);
         tick(1);
         cmp_req(cpu_req_ff, 7'h00);
      end
      wr(8'hc9, 8'h04);
      rd(8'hc9, 8'h00);
      fl = 16'h7fff;
      flags(fl);
      ev(5'h01);
      foreach (order[k]) begin
         tick(1);
         cmp_req(cpu_req_ff, {3'h4, order[k]});
         fl[order[k]] = 1'b0;
         flags(fl);
      end
      wr(8'ha8, 8'h7f);
      flags(16'h0001);
      tick(1);
      cmp_req(cpu_req_ff, 7'h00);
      wr(8'ha8, 8'hfe);
      tick(1);
      cmp_req(cpu_req_ff, 7'h00);
      wr(8'ha8, 8'hff);
      tick(1);
      cmp_req(cpu_req_ff, 7'h40);
      flags(16'h0000);
      {timer.compare_reg_zero, timer.compare_reg_one} = {16'h0001, 16'h1234};
      timer.compare_reg_two = 16'h2222;
      external_request_zero = 1'b1;
      hw(16'h0001);
      capture_input[3] = 1'b1;
      hw(16'h0200);
      {timer.tick, timer.count} = {1'b1, 16'h1234};
      hw(16'h1000);
      {timer.tick, timer.count} = {1'b1, 16'h12ff};
      hw(16'h4000);
      {timer.tick, timer.count} = {1'b1, 16'hffff};
      hw(16'hc000);
      {timer.tick, timer.count} = {1'b1, 16'h0001};
      hw(16'h0800);
      wr(8'hb8, 8'hff);
      rd(8'hb8, 8'h7f);
      wr(8'hb8, 8'h14);
      wr(8'hf7, 8'h01);
      rd(8'hf7, 8'h01);
      flags(16'h0005);
      tick(1);
      cmp_req(cpu_req_ff, 7'h52);
      lag = 2'h2;
      ack_en = 1'b1;
      wis(4'h2);
      flags(16'h0001);
      tick(2);
      cmp_req(cpu_req_ff, 7'h00);
      flags(16'h0041);
      wis(4'h6);
      ack_en = 1'b0;
      rd(8'hca, 8'h06);
      ret();
      wis(4'h2);
      tick(1);
      cmp_req(cpu_req_ff, 7'h66);
      flags(16'h0001);
      ret();
      wis(4'h0);
      tick(1);
      cmp_req(cpu_req_ff, 7'h40);
      wr(8'hb7, 8'h81);
      rd(8'hb7, 8'h01);
      tick(1);
      cmp_req(cpu_req_ff, 7'h60);
      wr(8'hb8, 8'h15);
      tick(1);
      cmp_req(cpu_req_ff, 7'h70);
      reset_n = 1'b0;
      tick(2);
      reset_n = 1'b1;
      cmp_req(cpu_req_ff, 7'h00);
      rd(8'hb8, 8'h00);
      test_done();
   end
endmodule : four_level_interrupt_controller_test
